// File: hdl/sof_pkg.sv
// Shared constants and types for the skip-on-flag instruction executor.
// Assumes a 10-bit opcode word and a 32-bit AXI4-Lite register bus.
package sof_pkg;

  // ==========================================================================
  // Opcode values
  localparam logic [9:0] OP_SKIP_TIMER_B  = 10'h281;
  localparam logic [9:0] OP_SKIP_TIMER_C  = 10'h282;
  localparam logic [9:0] OP_SKIP_VOLT_DET = 10'h28A;
  localparam logic [9:0] OP_SW_RESET      = 10'h001;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_IRQ_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_IRQ_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_REQ_FLAGS    = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS   = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h10;

  // ==========================================================================
  // Field positions and widths
  localparam int CTRL_W          = 4;
  localparam int BIT_TIMER_B_EN  = 3;  // In irq_control_reg_one
  localparam int BIT_TIMER_C_EN  = 0;  // In irq_control_reg_two
  localparam int BIT_VOLT_DET_EN = 3;  // In irq_control_reg_two
  localparam int NUM_FLAGS       = 3;
  localparam int FLAG_TIMER_B    = 0;
  localparam int FLAG_TIMER_C    = 1;
  localparam int FLAG_VOLT_DET   = 2;
  localparam int IRQ_W           = 5;
  localparam int EVT_SKIP        = 0;
  localparam int EVT_SW_RESET    = 1;
  localparam int EVT_FLAG_BASE   = 2;

  // ==========================================================================
  // Reset values and bus answers
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
  localparam logic [IRQ_W-1:0]  IRQ_RESET  = 5'h00;
  localparam logic [1:0]        RESP_OKAY   = 2'h0;
  localparam logic [1:0]        RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic skip_timer_b;
    logic skip_timer_c;
    logic skip_volt_det;
    logic sw_reset;
  } sof_decode_type;

  typedef enum logic [0:0] {WR_IDLE, WR_RESP} sof_wr_state_type;

endpackage

// File: hdl/sof_decoder.sv
// Opcode decoder for the skip-on-flag instruction group.
// Assumes the opcode is stable for the cycle in which it is qualified.
`timescale 1ns/1ns
`default_nettype none
module sof_decoder #(
  parameter int OPCODE_W = 10
) (
  // Instruction word
  input  wire logic [OPCODE_W-1:0] opcode,
  input  wire logic                op_valid,
  // Decoded strobes
  output sof_pkg::sof_decode_type  dec
);

  // ==========================================================================
  // Elaboration check
  if (OPCODE_W != 10) begin : g_bad_width
    $error("sof_decoder: opcode width must be 10");
  end

  // Exact-match compare; every code in the group is a full single word
  function automatic logic op_is(input logic [OPCODE_W-1:0] op, input logic [9:0] code);
    op_is = (op == code);
  endfunction

  // ==========================================================================
  // Decode
  assign dec.skip_timer_b  = op_valid & op_is(opcode, sof_pkg::OP_SKIP_TIMER_B);  // [RULE1]
  assign dec.skip_timer_c  = op_valid & op_is(opcode, sof_pkg::OP_SKIP_TIMER_C);  // [RULE4]
  assign dec.skip_volt_det = op_valid & op_is(opcode, sof_pkg::OP_SKIP_VOLT_DET); // [RULE7]
  assign dec.sw_reset      = op_valid & op_is(opcode, sof_pkg::OP_SW_RESET);      // [RULE10]

endmodule
`default_nettype wire

// File: hdl/sof_flag_cell.sv
// Sticky request flag: a set and a clear strobe, set dominant.
// Assumes both strobes are single-cycle and synchronous to aclk.
`timescale 1ns/1ns
`default_nettype none
module sof_flag_cell (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Strobes
  input  wire logic set_pulse,
  input  wire logic clr_pulse,
  // State
  output logic      flag_reg
);

  // ==========================================================================
  // Set wins so an event landing on the clearing cycle is not lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= 1'b0;
    end else if (set_pulse) begin
      flag_reg <= 1'b1;
    end else if (clr_pulse) begin
      flag_reg <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: hdl/sof_exec.sv
// Execution logic for the skip-on-flag instruction group and software reset.
// Assumes one qualified opcode per instruction cycle, flag set strobes from
// the timers and the voltage detector, and an AXI4-Lite master on aclk.
//
// Behaviour
// [RULE1] Opcode 0x281 is the one-word, one-cycle timer-b flag test-and-skip.
// [RULE2] With timer-b enable at 0 and its flag at 1, skip the next word and clear the flag.
// [RULE3] With bit 3 of irq_control_reg_one at 1, the timer-b test does nothing.
// [RULE4] Opcode 0x282 is the one-word, one-cycle timer-c flag test-and-skip.
// [RULE5] With timer-c enable at 0 and its flag at 1, skip the next word and clear the flag.
// [RULE6] With timer-c enable at 1, the timer-c test does nothing and keeps the flag.
// [RULE7] Opcode 0x28A is the one-word, one-cycle voltage-detector flag test-and-skip.
// [RULE8] With detector enable at 0 and its flag at 1, skip the next word.
// [RULE9] With detector enable at 1, the detector test does nothing.
// [RULE10] Opcode 0x001 requests the same system reset as the external reset.
`timescale 1ns/1ns
`default_nettype none
module sof_exec #(
  parameter int OPCODE_W = 10,
  parameter int ADDR_W   = 8
) (
  // Clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // Instruction stream
  input  wire logic [OPCODE_W-1:0] instr_opcode,
  input  wire logic                instr_valid,
  // Flag set events from peripherals
  input  wire logic                timer_b_event,
  input  wire logic                timer_c_event,
  input  wire logic                volt_det_event,
  // Execution results
  output logic                     skip_next_reg,
  output logic                     sys_reset_req_reg,
  output logic                     irq_reg,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  // ==========================================================================
  // Elaboration checks
  if (ADDR_W < 5) begin : g_bad_addr
    $error("sof_exec: address width too small for the register map");
  end

  // ==========================================================================
  // Declarations
  sof_pkg::sof_decode_type             dec;
  logic [sof_pkg::NUM_FLAGS-1:0]       req_flag;
  logic [sof_pkg::NUM_FLAGS-1:0]       flag_clr;
  logic [sof_pkg::NUM_FLAGS-1:0]       flag_set;
  logic [sof_pkg::CTRL_W-1:0]          irq_ctrl_one_reg;
  logic [sof_pkg::CTRL_W-1:0]          irq_ctrl_two_reg;
  logic [sof_pkg::IRQ_W-1:0]           irq_status_reg;
  logic [sof_pkg::IRQ_W-1:0]           irq_mask_reg;
  logic [sof_pkg::IRQ_W-1:0]           irq_event;
  logic [sof_pkg::IRQ_W-1:0]           irq_status_next;
  logic                                timer_b_irq_enable_bit;
  logic                                timer_c_irq_enable_bit;
  logic                                volt_det_irq_enable_bit;
  logic                                skip_timer_b_hit;
  logic                                skip_timer_c_hit;
  logic                                skip_volt_det_hit;
  logic                                skip_now;
  sof_pkg::sof_wr_state_type           wr_state_reg;
  logic                                aw_held_reg;
  logic                                w_held_reg;
  logic [ADDR_W-1:0]                   aw_addr_reg;
  logic [31:0]                         w_data_reg;
  logic [3:0]                          w_strb_reg;
  logic                                wr_fire;
  logic                                wr_hit;
  logic                                w1c_fire;
  logic [sof_pkg::IRQ_W-1:0]           w1c_bits;
  logic [31:0]                         rd_word;
  logic                                rd_hit;

  // Word-aligned register select, low two address bits ignored
  function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    addr_is = ({a[ADDR_W-1:2], 2'h0} == ADDR_W'(ofs));
  endfunction

  // Byte lane 0 carries every implemented field, so only wstrb[0] matters
  function automatic logic lane0(input logic [3:0] strb);
    lane0 = strb[0];
  endfunction

  // ==========================================================================
  // Decoder and request flags
  sof_decoder #(
    .OPCODE_W (OPCODE_W)
  ) u_decoder (
    .opcode   (instr_opcode),
    .op_valid (instr_valid),
    .dec      (dec)
  );

  assign flag_set = {volt_det_event, timer_c_event, timer_b_event};

  // One sticky cell per interrupt request flag
  for (genvar i = 0; i < sof_pkg::NUM_FLAGS; i++) begin : g_flag
    sof_flag_cell u_cell (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .set_pulse (flag_set[i]),
      .clr_pulse (flag_clr[i]),
      .flag_reg  (req_flag[i])
    );
  end

  // ==========================================================================
  // Enable bits gate each test into a no-operation when set
  assign timer_b_irq_enable_bit  = irq_ctrl_one_reg[sof_pkg::BIT_TIMER_B_EN];  // [RULE3]
  assign timer_c_irq_enable_bit  = irq_ctrl_two_reg[sof_pkg::BIT_TIMER_C_EN];  // [RULE6]
  assign volt_det_irq_enable_bit = irq_ctrl_two_reg[sof_pkg::BIT_VOLT_DET_EN]; // [RULE9]

  // Skip conditions: enable clear and flag set
  assign skip_timer_b_hit = dec.skip_timer_b & ~timer_b_irq_enable_bit
                          & req_flag[sof_pkg::FLAG_TIMER_B];                     // [RULE2]
  assign skip_timer_c_hit = dec.skip_timer_c & ~timer_c_irq_enable_bit
                          & req_flag[sof_pkg::FLAG_TIMER_C];                     // [RULE5]
  assign skip_volt_det_hit = dec.skip_volt_det & ~volt_det_irq_enable_bit
                           & req_flag[sof_pkg::FLAG_VOLT_DET];                   // [RULE8]
  assign skip_now = skip_timer_b_hit | skip_timer_c_hit | skip_volt_det_hit;

  // Timer flags are consumed by a taken skip; the detector flag is left
  // standing so software can still see the supply dip afterwards
  assign flag_clr[sof_pkg::FLAG_TIMER_B]  = skip_timer_b_hit;  // [RULE2]
  assign flag_clr[sof_pkg::FLAG_TIMER_C]  = skip_timer_c_hit;  // [RULE5]
  assign flag_clr[sof_pkg::FLAG_VOLT_DET] = 1'b0;              // [RULE8]

  // ==========================================================================
  // Execution results, registered one cycle after the instruction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      skip_next_reg <= 1'b0;
    end else begin
      skip_next_reg <= skip_now;  // [RULE2] [RULE5] [RULE8]
    end
  end

  // Software reset leaves as a pulse; the chip reset logic drives aresetn
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sys_reset_req_reg <= 1'b0;
    end else begin
      sys_reset_req_reg <= dec.sw_reset;  // [RULE10]
    end
  end

  // ==========================================================================
  // Interrupt status: sticky, write one to clear, set beats clear
  assign irq_event[sof_pkg::EVT_SKIP]     = skip_now;
  assign irq_event[sof_pkg::EVT_SW_RESET] = dec.sw_reset;
  assign irq_event[sof_pkg::EVT_FLAG_BASE +: sof_pkg::NUM_FLAGS] = flag_set;

  assign w1c_fire = wr_fire & addr_is(aw_addr_reg, sof_pkg::OFS_IRQ_STATUS)
                  & lane0(w_strb_reg);
  assign w1c_bits = w1c_fire ? w_data_reg[sof_pkg::IRQ_W-1:0] : sof_pkg::IRQ_RESET;
  assign irq_status_next = (irq_status_reg & ~w1c_bits) | irq_event;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= sof_pkg::IRQ_RESET;
    end else begin
      irq_status_reg <= irq_status_next;
    end
  end

  // Level output from a flop; lags the status by one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // ==========================================================================
  // AXI write channel: address and data taken in either order
  assign wr_fire = (wr_state_reg == sof_pkg::WR_IDLE) & aw_held_reg & w_held_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  // Ready flops drop on the taking edge so each channel holds one item
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_held_reg & ~(s_axi_awvalid & s_axi_awready)
                     & (wr_state_reg == sof_pkg::WR_IDLE) & ~wr_fire;
      s_axi_wready  <= ~w_held_reg & ~(s_axi_wvalid & s_axi_wready)
                     & (wr_state_reg == sof_pkg::WR_IDLE) & ~wr_fire;
    end
  end

  // Response state machine
  assign wr_hit = addr_is(aw_addr_reg, sof_pkg::OFS_IRQ_CTRL_ONE)
                | addr_is(aw_addr_reg, sof_pkg::OFS_IRQ_CTRL_TWO)
                | addr_is(aw_addr_reg, sof_pkg::OFS_REQ_FLAGS)
                | addr_is(aw_addr_reg, sof_pkg::OFS_IRQ_STATUS)
                | addr_is(aw_addr_reg, sof_pkg::OFS_IRQ_MASK);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= sof_pkg::WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= sof_pkg::RESP_OKAY;
    end else begin
      case (wr_state_reg)
        sof_pkg::WR_IDLE: begin
          if (wr_fire) begin
            wr_state_reg <= sof_pkg::WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? sof_pkg::RESP_OKAY : sof_pkg::RESP_SLVERR;
          end
        end
        sof_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg <= sof_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state_reg <= sof_pkg::WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Software-written registers; the flag register reads only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_ctrl_one_reg <= sof_pkg::CTRL_RESET;
      irq_ctrl_two_reg <= sof_pkg::CTRL_RESET;
      irq_mask_reg     <= sof_pkg::IRQ_RESET;
    end else if (wr_fire && lane0(w_strb_reg)) begin
      if (addr_is(aw_addr_reg, sof_pkg::OFS_IRQ_CTRL_ONE)) begin
        irq_ctrl_one_reg <= w_data_reg[sof_pkg::CTRL_W-1:0];
      end
      if (addr_is(aw_addr_reg, sof_pkg::OFS_IRQ_CTRL_TWO)) begin
        irq_ctrl_two_reg <= w_data_reg[sof_pkg::CTRL_W-1:0];
      end
      if (addr_is(aw_addr_reg, sof_pkg::OFS_IRQ_MASK)) begin
        irq_mask_reg <= w_data_reg[sof_pkg::IRQ_W-1:0];
      end
    end
  end

  // ==========================================================================
  // AXI read channel: one outstanding read, answer one cycle after taking
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (addr_is(s_axi_araddr, sof_pkg::OFS_IRQ_CTRL_ONE)) begin
      rd_word[sof_pkg::CTRL_W-1:0] = irq_ctrl_one_reg;
    end else if (addr_is(s_axi_araddr, sof_pkg::OFS_IRQ_CTRL_TWO)) begin
      rd_word[sof_pkg::CTRL_W-1:0] = irq_ctrl_two_reg;
    end else if (addr_is(s_axi_araddr, sof_pkg::OFS_REQ_FLAGS)) begin
      rd_word[sof_pkg::NUM_FLAGS-1:0] = req_flag;
    end else if (addr_is(s_axi_araddr, sof_pkg::OFS_IRQ_STATUS)) begin
      rd_word[sof_pkg::IRQ_W-1:0] = irq_status_reg;
    end else if (addr_is(s_axi_araddr, sof_pkg::OFS_IRQ_MASK)) begin
      rd_word[sof_pkg::IRQ_W-1:0] = irq_mask_reg;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Unmapped reads return zero with a slave error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= sof_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_word;
      s_axi_rresp   <= rd_hit ? sof_pkg::RESP_OKAY : sof_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid) begin
      if (s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end else begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// File: tb/sof_exec_asserts.sv
// Port checker for the skip-on-flag executor.
// Assumes a bind onto sof_exec, with everything on aclk.
`timescale 1ns/1ns
`default_nettype none
module sof_exec_asserts #(
  parameter int OPCODE_W = 10,
  parameter int ADDR_W   = 8
) (
  // Clock and reset
  input wire logic                aclk,
  input wire logic                aresetn,
  // Instruction side
  input wire logic [OPCODE_W-1:0] instr_opcode,
  input wire logic                instr_valid,
  input wire logic                timer_b_event,
  input wire logic                timer_c_event,
  input wire logic                skip_next_reg,
  input wire logic                sys_reset_req_reg,
  // Bus side
  input wire logic                s_axi_awready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [31:0]         s_axi_rdata
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================================
  // Executed words, decoded here without the design's decoder
  logic go_b, go_c, go_v, go_r;
  assign go_b = instr_valid && instr_opcode == sof_pkg::OP_SKIP_TIMER_B;
  assign go_c = instr_valid && instr_opcode == sof_pkg::OP_SKIP_TIMER_C;
  assign go_v = instr_valid && instr_opcode == sof_pkg::OP_SKIP_VOLT_DET;
  assign go_r = instr_valid && instr_opcode == sof_pkg::OP_SW_RESET;
  // ==========================================================================
  // Skips; an idle awready means no enable write can land in the window
  a_skip_cause: assert property (
    skip_next_reg |-> $past(go_b || go_c || go_v))
    else $error("skip without a test word");
  a_skip_b_clears: assert property ((go_b && !timer_b_event) ##1
    (go_b && skip_next_reg && !timer_b_event) |=> !skip_next_reg)
    else $error("timer b flag survived its skip");
  a_skip_c_clears: assert property ((go_c && !timer_c_event) ##1
    (go_c && skip_next_reg && !timer_c_event) |=> !skip_next_reg)
    else $error("timer c flag survived its skip");
  a_skip_vd_keeps: assert property ((go_v && s_axi_awready) ##1
    (go_v && skip_next_reg && s_axi_awready) |=> skip_next_reg)
    else $error("detector flag lost after skip");
  // ==========================================================================
  // Software reset request
  a_reset_pulse: assert property (go_r |=> sys_reset_req_reg)
    else $error("reset word gave no request");
  a_reset_cause: assert property (sys_reset_req_reg |-> $past(go_r))
    else $error("reset request without reset word");
  // ==========================================================================
  // Bus answers hold until taken
  a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
endmodule
bind sof_exec sof_exec_asserts #(.OPCODE_W(OPCODE_W), .ADDR_W(ADDR_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .instr_opcode(instr_opcode), .instr_valid(instr_valid),
  .timer_b_event(timer_b_event), .timer_c_event(timer_c_event),
  .skip_next_reg(skip_next_reg), .sys_reset_req_reg(sys_reset_req_reg),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata));
`default_nettype wire

// File: tb/test_skip_on_flag_instr_exec.sv
// Self-checking bench for the skip-on-flag executor.
// Assumes sof_exec alone, driven on its instruction and AXI4-Lite ports.
`timescale 1ns/1ns
`default_nettype none
module test_skip_on_flag_instr_exec;
  // ==========================================================================
  // Stimulus and observation
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [9:0]  op_q = 10'h000;
  logic        op_v = 1'b0;
  logic [2:0]  evt = 3'h0;
  logic        skip, sreq, irq, awv = 1'b0, wv = 1'b0, bv, brd = 1'b0;
  logic        awr, wr_rdy, arr, arv = 1'b0, rv, rrd = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdat;
  logic [1:0]  br, rr;
  int          failures = 0;
  int          checks_done = 0;
  logic [9:0]  ops [3] = '{sof_pkg::OP_SKIP_TIMER_B, sof_pkg::OP_SKIP_TIMER_C,
                           sof_pkg::OP_SKIP_VOLT_DET};
  logic [7:0]  en_ofs [3] = '{sof_pkg::OFS_IRQ_CTRL_ONE, sof_pkg::OFS_IRQ_CTRL_TWO,
                              sof_pkg::OFS_IRQ_CTRL_TWO};
  logic [31:0] en_val [3] = '{32'h8, 32'h1, 32'h8};
  logic [7:0]  offs [5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  // Free-running 100 MHz clock
  always #5 aclk = ~aclk;
  sof_exec uut (
    .aclk(aclk), .aresetn(aresetn), .instr_opcode(op_q), .instr_valid(op_v),
    .timer_b_event(evt[0]), .timer_c_event(evt[1]), .volt_det_event(evt[2]),
    .skip_next_reg(skip), .sys_reset_req_reg(sreq), .irq_reg(irq),
    .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(brd),
    .s_axi_araddr(ara), .s_axi_arprot(3'h0), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rrd));
  // ==========================================================================
  // Compare and finish
  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // Bus and instruction drivers; handshakes judged on sampled values
  // Answer ready rises only once the answer is seen, so the slave must hold it
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
      if (bv && !brd) brd <= 1'b1;
    end while (!(bv && brd));
    brd <= 1'b0;
    check("bresp", br, er);
  endtask
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] m,
                    input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv && !rrd) rrd <= 1'b1;
    end while (!(rv && rrd));
    rrd <= 1'b0;
    check(n, rdat & m, e);
    check("rresp", rr, er);
  endtask
  // Issues one word n times back to back; e holds the skip seen after each
  task automatic exec(input logic [9:0] op, input int n, input logic [1:0] e);
    @(posedge aclk);
    op_q <= op;
    op_v <= 1'b1;
    for (int k = 0; k < n; k++) begin
      @(posedge aclk);
      if (k == n - 1) op_v <= 1'b0;
      #1;
      check("skip", skip, e[k]);
      check("sysreset", sreq, op == sof_pkg::OP_SW_RESET);
    end
  endtask
  task automatic pulse(input int i);
    @(posedge aclk);
    evt[i] <= 1'b1;
    @(posedge aclk);
    evt <= 3'h0;
  endtask
  // ==========================================================================
  // Test sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd("reset", offs[i], 32'hFFFFFFFF, 32'h0, 2'h0);
    $display("Test reset done");
    // Each test word: taken skip, repeat, then disabled
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      rd("flag", 8'h08, 32'(1 << i), 32'(1 << i), 2'h0);
      exec(ops[i], 2, {i == 2, 1'b1});
      rd("flag", 8'h08, 32'(1 << i), (i == 2) ? 32'h4 : 32'h0, 2'h0);
      wr(en_ofs[i], en_val[i], 2'h0);
      pulse(i);
      exec(ops[i], 1, 2'b00);
      rd("flag", 8'h08, 32'(1 << i), 32'(1 << i), 2'h0);
      wr(en_ofs[i], 32'h0, 2'h0);
      if (i < 2) exec(ops[i], 1, 2'b01);
    end
    exec(10'h280, 1, 2'b00);
    $display("Test skips done");
    // Sticky status, mask and interrupt level
    rd("status", 8'h0C, 32'h1F, 32'h1D, 2'h0);
    check("irq", irq, 1'b0);
    wr(8'h10, 32'h1, 2'h0);
    @(posedge aclk);
    #1;
    check("irq", irq, 1'b1);
    wr(8'h0C, 32'h1F, 2'h0);
    repeat (2) @(posedge aclk);
    #1;
    check("irq", irq, 1'b0);
    rd("status", 8'h0C, 32'h1F, 32'h0, 2'h0);
    wr(8'h40, 32'h1, 2'h2);
    rd("unmapped", 8'h40, 32'hFFFFFFFF, 32'h0, 2'h2);
    $display("Test interrupt done");
    // Software reset, then outer logic resets the block
    exec(sof_pkg::OP_SW_RESET, 1, 2'b00);
    rd("status", 8'h0C, 32'h1F, 32'h2, 2'h0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) rd("rereset", offs[i], 32'hFFFFFFFF, 32'h0, 2'h0);
    $display("Test software reset done");
    wrap_up;
  end
  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    wrap_up;
  end
endmodule
`default_nettype wire
